// >>> verilog/bcfb_pkg.sv
// constants and types shared by the bit-clear and flag-branch block
package bcfb_pkg;
  // top nibble of the bit-clear opcode and of the conditional branches
  localparam logic [3:0] OP_CLEAR = 4'h9;
  localparam logic [3:0] OP_BRANCH = 4'hE;
  // condition codes held in bits 11:8 of a conditional branch
  localparam logic [3:0] COND_CARRY = 4'h2;
  localparam logic [3:0] COND_NO_CARRY = 4'h3;
  localparam logic [3:0] COND_NEG = 4'h6;
  localparam logic [3:0] COND_NOT_NEG = 4'h7;
  // access bank: low half maps to bank 0, high half to the top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  // program counter step to the next instruction word
  localparam int unsigned PC_STEP = 2;
  // apb register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_BANK = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_LAST_PC = 12'h00C;
  localparam logic [11:0] REG_COUNT = 12'h010;
  // values after reset
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [3:0] BANK_RESET = 4'h0;
  // status register bit positions
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_TAKEN_BIT = 1;
  localparam int unsigned STAT_UNKNOWN_BIT = 2;
  // one instruction cycle is four phases of the system clock
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1 = 3'b001,
    PH_Q2 = 3'b010,
    PH_Q3 = 3'b011,
    PH_Q4 = 3'b100
  } bcfb_phase_type;
endpackage : bcfb_pkg

// >>> verilog/bcfb_decode.sv
// instruction field decoder for bit-clear and flag branches
`timescale 1ns/1ps
`default_nettype none
module bcfb_decode (
  input wire logic [15:0] instr_in,
  input wire logic [3:0] bank_in,
  input wire logic flag_n_in,
  input wire logic flag_c_in,
  output logic is_clear_out,
  output logic is_branch_out,
  output logic cond_true_out,
  output logic [7:0] clear_mask_out,
  output logic [11:0] data_addr_out,
  output logic [7:0] offset_out
);
  // evaluate a branch condition code against the live flags
  function automatic logic cond_eval(input logic [3:0] code, input logic n, input logic c);
    case (code)
      bcfb_pkg::COND_CARRY: cond_eval = c;
      bcfb_pkg::COND_NO_CARRY: cond_eval = ~c;
      bcfb_pkg::COND_NEG: cond_eval = n;
      bcfb_pkg::COND_NOT_NEG: cond_eval = ~n;
      default: cond_eval = 1'b0;
    endcase
  endfunction : cond_eval

  // form the data address from the bank-access flag and file address
  function automatic logic [11:0] form_addr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank);
    if (!a) begin
      // access bank: bank register ignored
      form_addr = (f < bcfb_pkg::ACCESS_SPLIT) ? {bcfb_pkg::ACCESS_LO_BANK, f}
                                               : {bcfb_pkg::ACCESS_HI_BANK, f};
    end else begin
      form_addr = {bank, f};
    end
  endfunction : form_addr

  // field extraction; other conditional codes are not handled here
  always_comb begin
    is_clear_out = (instr_in[15:12] == bcfb_pkg::OP_CLEAR);
    is_branch_out = (instr_in[15:12] == bcfb_pkg::OP_BRANCH) &&
                    ((instr_in[11:8] == bcfb_pkg::COND_CARRY) ||
                     (instr_in[11:8] == bcfb_pkg::COND_NO_CARRY) ||
                     (instr_in[11:8] == bcfb_pkg::COND_NEG) ||
                     (instr_in[11:8] == bcfb_pkg::COND_NOT_NEG));
    cond_true_out = cond_eval(instr_in[11:8], flag_n_in, flag_c_in);
    clear_mask_out = ~(8'h01 << instr_in[11:9]);
    data_addr_out = form_addr(instr_in[8], instr_in[7:0], bank_in);
    offset_out = instr_in[7:0];
  end
endmodule : bcfb_decode
`default_nettype wire

// >>> verilog/bcfb_target.sv
// relative branch target adder
`timescale 1ns/1ps
`default_nettype none
module bcfb_target #(
  parameter int unsigned PC_W = 21
) (
  input wire logic [PC_W-1:0] instr_addr_in,
  input wire logic [7:0] offset_in,
  output logic [PC_W-1:0] target_out
);
  logic [PC_W-1:0] disp;
  // sign extend the offset and double it to a byte displacement
  always_comb begin
    disp = {{(PC_W-9){offset_in[7]}}, offset_in, 1'b0};
    target_out = instr_addr_in + PC_W'(bcfb_pkg::PC_STEP) + disp;
  end
endmodule : bcfb_target
`default_nettype wire

// >>> verilog/bcfb_core.sv
// bit-clear and flag-branch execution unit with apb control registers
`timescale 1ns/1ps
`default_nettype none
module bcfb_core #(
  parameter int unsigned PC_W = 21
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // fetch unit side
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [PC_W-1:0] instr_addr_in,
  output logic instr_ready_out,
  output logic instr_done_out,
  output logic pc_load_out,
  output logic [PC_W-1:0] pc_out,
  // status flags, read only
  input wire logic flag_n_in,
  input wire logic flag_c_in,
  // data memory port
  output logic [11:0] dmem_addr_out,
  output logic dmem_rd_out,
  input wire logic [7:0] dmem_rdata_in,
  output logic dmem_wr_out,
  output logic [7:0] dmem_wdata_out
);
  // whole state of the unit, outputs included, in one record
  typedef struct packed {
    bcfb_pkg::bcfb_phase_type phase;
    logic second;
    logic [15:0] instr;
    logic [PC_W-1:0] iaddr;
    logic taken;
    logic clear;
    logic unknown;
    logic ready;
    logic done;
    logic [11:0] dmem_addr;
    logic dmem_rd;
    logic dmem_wr;
    logic [7:0] dmem_wdata;
    logic pc_load;
    logic [PC_W-1:0] pc;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic enable;
    logic [3:0] bank_selection_register;
    logic last_taken;
    logic last_unknown;
    logic [15:0] count;
  } bcfb_state_type;

  bcfb_state_type s;
  bcfb_state_type next_s;

  logic d_clear;
  logic d_branch;
  logic d_cond;
  logic [7:0] d_mask;
  logic [11:0] d_addr;
  logic [7:0] d_offset;
  logic [PC_W-1:0] d_target;

  // field decode works on the latched word, never on the live input
  bcfb_decode u_decode (
    .instr_in(s.instr),
    .bank_in(s.bank_selection_register),
    .flag_n_in(flag_n_in),
    .flag_c_in(flag_c_in),
    .is_clear_out(d_clear),
    .is_branch_out(d_branch),
    .cond_true_out(d_cond),
    .clear_mask_out(d_mask),
    .data_addr_out(d_addr),
    .offset_out(d_offset)
  );

  // branch target from the address of the branch itself
  bcfb_target #(
    .PC_W(PC_W)
  ) u_target (
    .instr_addr_in(s.iaddr),
    .offset_in(d_offset),
    .target_out(d_target)
  );

  // address decode for the error answer; read data decodes the address in its own case
  function automatic logic reg_hit(input logic [11:0] addr);
    reg_hit = (addr == bcfb_pkg::REG_CTRL) || (addr == bcfb_pkg::REG_BANK) ||
              (addr == bcfb_pkg::REG_STATUS) || (addr == bcfb_pkg::REG_LAST_PC) ||
              (addr == bcfb_pkg::REG_COUNT);
  endfunction : reg_hit

  // next state: execution sequencer and apb slave
  always_comb begin
    next_s = s;
    // strobes last one cycle unless set again below
    next_s.dmem_rd = 1'b0;
    next_s.dmem_wr = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.done = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h0000_0000;

    case (s.phase)
      bcfb_pkg::PH_IDLE: begin
        if (s.ready && instr_valid_in) begin
          next_s.instr = instr_in;
          next_s.iaddr = instr_addr_in;
          next_s.ready = 1'b0;
          next_s.second = 1'b0;
          next_s.phase = bcfb_pkg::PH_Q1;
        end else begin
          // disabling stops new work but lets a running one finish
          next_s.ready = s.enable;
        end
      end
      bcfb_pkg::PH_Q1: begin
        // decode; flags are sampled once here for the whole branch
        if (!s.second) begin
          next_s.clear = d_clear;
          next_s.taken = d_branch && d_cond;
          next_s.unknown = !d_clear && !d_branch;
          next_s.dmem_addr = d_clear ? d_addr : s.dmem_addr;
          next_s.dmem_rd = d_clear;
        end
        next_s.phase = bcfb_pkg::PH_Q2;
      end
      bcfb_pkg::PH_Q2: begin
        // register read or offset read happens in this phase
        next_s.phase = bcfb_pkg::PH_Q3;
      end
      bcfb_pkg::PH_Q3: begin
        // process data: clear the bit or form the branch target
        if (!s.second && s.clear) begin
          next_s.dmem_wdata = dmem_rdata_in & d_mask;
          next_s.dmem_wr = 1'b1;
        end
        if (!s.second && s.taken) begin
          next_s.pc = d_target;
          next_s.pc_load = 1'b1;
        end
        // a failed branch loads nothing: fetch keeps address plus two
        next_s.phase = bcfb_pkg::PH_Q4;
      end
      bcfb_pkg::PH_Q4: begin
        if (!s.second && s.taken) begin
          // taken branch spends a whole second cycle doing nothing
          next_s.second = 1'b1;
          next_s.phase = bcfb_pkg::PH_Q1;
        end else begin
          next_s.phase = bcfb_pkg::PH_IDLE;
          next_s.done = 1'b1;
          next_s.ready = s.enable;
          next_s.last_taken = s.taken;
          next_s.last_unknown = s.unknown;
          next_s.count = s.count + 16'h0001;
        end
      end
      default: begin
        next_s.phase = bcfb_pkg::PH_IDLE;
      end
    endcase

    // apb setup cycle: answer in the following access cycle
    if (psel_in && !penable_in) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !reg_hit(paddr_in);
      if (!pwrite_in) begin
        case (paddr_in)
          bcfb_pkg::REG_CTRL: begin
            next_s.prdata = {31'h0000_0000, s.enable};
          end
          bcfb_pkg::REG_BANK: begin
            next_s.prdata = {28'h000_0000, s.bank_selection_register};
          end
          bcfb_pkg::REG_STATUS: begin
            next_s.prdata[bcfb_pkg::STAT_BUSY_BIT] = (s.phase != bcfb_pkg::PH_IDLE);
            next_s.prdata[bcfb_pkg::STAT_TAKEN_BIT] = s.last_taken;
            next_s.prdata[bcfb_pkg::STAT_UNKNOWN_BIT] = s.last_unknown;
          end
          bcfb_pkg::REG_LAST_PC: begin
            next_s.prdata = 32'(s.pc);
          end
          bcfb_pkg::REG_COUNT: begin
            next_s.prdata = {16'h0000, s.count};
          end
          default: begin
            next_s.prdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // writes take effect only at the completing access edge
    if (psel_in && penable_in && s.pready && pwrite_in) begin
      case (paddr_in)
        bcfb_pkg::REG_CTRL: begin
          next_s.enable = pwdata_in[0];
        end
        bcfb_pkg::REG_BANK: begin
          // a clear in flight already latched its address in Q1
          next_s.bank_selection_register = pwdata_in[3:0];
        end
        bcfb_pkg::REG_COUNT: begin
          next_s.count = 16'h0000;
        end
        default: begin
          next_s.count = next_s.count;
        end
      endcase
    end
  end

  // state register; constants only under reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
      s.phase <= bcfb_pkg::PH_IDLE;
      s.enable <= bcfb_pkg::CTRL_RESET;
      s.bank_selection_register <= bcfb_pkg::BANK_RESET;
    end else begin
      s <= next_s;
    end
  end

  // every output straight from the state record
  assign pready_out = s.pready;
  assign prdata_out = s.prdata;
  assign pslverr_out = s.pslverr;
  assign instr_ready_out = s.ready;
  assign instr_done_out = s.done;
  assign pc_load_out = s.pc_load;
  assign pc_out = s.pc;
  assign dmem_addr_out = s.dmem_addr;
  assign dmem_rd_out = s.dmem_rd;
  assign dmem_wr_out = s.dmem_wr;
  assign dmem_wdata_out = s.dmem_wdata;
endmodule : bcfb_core
`default_nettype wire

// >>> bench/bcfb_monitor.sv
// assertion checker for the bit-clear and flag-branch core
`timescale 1ns/1ps
`default_nettype none
module bcfb_monitor #(
  parameter int unsigned PC_W = 21
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [PC_W-1:0] instr_addr_in,
  input wire logic instr_ready_out,
  input wire logic instr_done_out,
  input wire logic pc_load_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic flag_n_in,
  input wire logic flag_c_in,
  input wire logic [11:0] dmem_addr_out,
  input wire logic dmem_rd_out,
  input wire logic [7:0] dmem_rdata_in,
  input wire logic dmem_wr_out,
  input wire logic [7:0] dmem_wdata_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic [3:0] cnt;
  logic [15:0] iq;
  logic [PC_W-1:0] aq;
  logic nq, cq, hit, br;
  // condition outcome; unlisted codes never branch
  always_comb begin
    br = iq[15:12] == bcfb_pkg::OP_BRANCH;
    case (iq[11:8])
      bcfb_pkg::COND_CARRY: hit = cq;
      bcfb_pkg::COND_NO_CARRY: hit = !cq;
      bcfb_pkg::COND_NEG: hit = nq;
      bcfb_pkg::COND_NOT_NEG: hit = !nq;
      default: hit = 1'b0;
    endcase
  end
  // phase count from the take; flags latched where the core samples them
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= '0;
      iq <= '0;
      aq <= '0;
      nq <= 1'b0;
      cq <= 1'b0;
    end else begin
      if (instr_valid_in && instr_ready_out) begin
        cnt <= 4'h1;
        iq <= instr_in;
        aq <= instr_addr_in;
      end else if (cnt != 4'h0 && cnt < 4'h9) cnt <= cnt + 4'h1;
      else cnt <= '0;
      if (cnt == 4'h1) begin
        nq <= flag_n_in;
        cq <= flag_c_in;
      end
    end
  end
  chk_clear_mask: assert property (dmem_wr_out |-> dmem_wdata_out ==
    ($past(dmem_rdata_in) & ~(8'h01 << iq[11:9]))) else $error("bit clear data wrong");
  chk_access_bank: assert property (dmem_rd_out && !iq[8] |-> dmem_addr_out ==
    {iq[7] ? 4'hF : 4'h0, iq[7:0]}) else $error("access bank address wrong");
  chk_cond_load: assert property (cnt == 4'h4 && br |-> pc_load_out == hit)
    else $error("branch decision wrong");
  chk_branch_target: assert property (pc_load_out |-> pc_out == aq + PC_W'(2) +
    {{(PC_W-9){iq[7]}}, iq[7:0], 1'b0}) else $error("branch target wrong");
  chk_taken_idle: assert property (pc_load_out |=> !instr_done_out [*4] ##1 instr_done_out)
    else $error("taken branch length wrong");
  chk_skip_done: assert property (cnt == 4'h4 && br && !hit |=> instr_done_out)
    else $error("untaken branch length wrong");
  chk_clear_rmw: assert property (dmem_rd_out |-> ##2 dmem_wr_out ##1 instr_done_out)
    else $error("read modify write order wrong");
  chk_apb_answer: assert property (psel_in && !penable_in |=> pready_out)
    else $error("apb answer late");
  chk_apb_unmapped: assert property (pready_out && paddr_in > 12'h010 |-> pslverr_out
    && prdata_out == 32'h0) else $error("unmapped access not refused");
  cov_taken: cover property (pc_load_out);
  cov_clear: cover property (dmem_wr_out);
  cov_refuse: cover property (pready_out && pslverr_out);
endmodule : bcfb_monitor
bind bcfb_core bcfb_monitor #(.PC_W(PC_W)) u_mon (
  .clk_sys_in(clk_sys_in),
  .arst_n_in(arst_n_in),
  .paddr_in(paddr_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pready_out(pready_out),
  .prdata_out(prdata_out),
  .pslverr_out(pslverr_out),
  .instr_valid_in(instr_valid_in),
  .instr_in(instr_in),
  .instr_addr_in(instr_addr_in),
  .instr_ready_out(instr_ready_out),
  .instr_done_out(instr_done_out),
  .pc_load_out(pc_load_out),
  .pc_out(pc_out),
  .flag_n_in(flag_n_in),
  .flag_c_in(flag_c_in),
  .dmem_addr_out(dmem_addr_out),
  .dmem_rd_out(dmem_rd_out),
  .dmem_rdata_in(dmem_rdata_in),
  .dmem_wr_out(dmem_wr_out),
  .dmem_wdata_out(dmem_wdata_out)
);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the bit-clear and flag-branch core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic instr_valid_in = 0, flag_n_in = 0, flag_c_in = 0;
  logic [11:0] paddr_in = 0, dmem_addr_out;
  logic [31:0] pwdata_in = 0, prdata_out;
  logic [15:0] instr_in = 0;
  logic [20:0] instr_addr_in = 0, pc_out;
  logic [7:0] dmem_rdata_in = 0, dmem_wdata_out;
  logic pready_out, pslverr_out, instr_ready_out, instr_done_out, pc_load_out;
  logic dmem_rd_out, dmem_wr_out;
  logic [32:0] q[$];
  int bad_count = 0, n_compared = 0, cyc = 0, n_done = 0;
  logic [3:0] codes [4] = '{bcfb_pkg::COND_CARRY, bcfb_pkg::COND_NO_CARRY,
    bcfb_pkg::COND_NEG, bcfb_pkg::COND_NOT_NEG};
  bcfb_core u_dut (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .paddr_in(paddr_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in),
    .pready_out(pready_out),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .instr_addr_in(instr_addr_in),
    .instr_ready_out(instr_ready_out),
    .instr_done_out(instr_done_out),
    .pc_load_out(pc_load_out),
    .pc_out(pc_out),
    .flag_n_in(flag_n_in),
    .flag_c_in(flag_c_in),
    .dmem_addr_out(dmem_addr_out),
    .dmem_rd_out(dmem_rd_out),
    .dmem_rdata_in(dmem_rdata_in),
    .dmem_wr_out(dmem_wr_out),
    .dmem_wdata_out(dmem_wdata_out)
  );
  initial forever #20 clk_sys_in = ~clk_sys_in;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // request held until pready is seen at a falling edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    logic r;
    @(posedge clk_sys_in);
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    psel_in <= 1'b1;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      r = pready_out;
      @(posedge clk_sys_in);
    end while (r !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  // offer one instruction, then count cycles to its done pulse
  task automatic exec(input logic [15:0] i, input int lat);
    logic r;
    int n;
    @(posedge clk_sys_in);
    instr_in <= i;
    instr_valid_in <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      r = instr_ready_out;
      @(posedge clk_sys_in);
    end while (r !== 1'b1);
    instr_valid_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (instr_done_out !== 1'b1 && n < 20);
    check(33'(n), 33'(lat));
    n_done++;
  endtask : exec
  // outputs are settled at the falling edge; oldest note is the one due
  always @(negedge clk_sys_in) begin
    if (pready_out === 1'b1 && pwrite_in === 1'b0)
      check({pslverr_out, prdata_out}, q.pop_front());
    if (dmem_wr_out === 1'b1)
      check(33'({dmem_addr_out, dmem_wdata_out}), q.pop_front());
    if (pc_load_out === 1'b1)
      check(33'(pc_out), q.pop_front());
  end
  // hang guard well above the few hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    logic [3:0] bank;
    logic [7:0] f, d, n;
    logic [2:0] b;
    logic [20:0] ad, tgt;
    logic nf, cf, hit;
    void'($urandom(34));
    tgt = 21'h0;
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    q.push_back({1'b0, 32'h1});
    apb(bcfb_pkg::REG_CTRL, 1'b0, 32'h0);
    q.push_back(33'h0);
    apb(bcfb_pkg::REG_BANK, 1'b0, 32'h0);
    q.push_back({1'b1, 32'h0});
    apb(12'h020, 1'b0, 32'h0);
    bank = 4'($urandom);
    apb(bcfb_pkg::REG_BANK, 1'b1, {28'h0, bank});
    q.push_back({1'b0, 28'h0, bank});
    apb(bcfb_pkg::REG_BANK, 1'b0, 32'h0);
    $display("test registers done");
    // both bank modes, both halves of the access bank
    for (int k = 0; k < 12; k++) begin
      @(posedge clk_sys_in);
      f = {k[1], 7'($urandom)};
      b = 3'($urandom);
      d = 8'($urandom);
      dmem_rdata_in <= d;
      q.push_back(33'({k[0] ? bank : (f[7] ? 4'hF : 4'h0), f, d & ~(8'h01 << b)}));
      exec({bcfb_pkg::OP_CLEAR, b, k[0], f}, 5);
    end
    $display("test bit clear done");
    // every condition code, random flags, offset extremes first
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys_in);
      n = k == 0 ? 8'h80 : (k == 1 ? 8'h7F : 8'($urandom));
      ad = 21'($urandom) & 21'h1FFFFE;
      nf = 1'($urandom);
      cf = 1'($urandom);
      hit = (k[1] ? nf : cf) ^ k[0];
      flag_n_in <= nf;
      flag_c_in <= cf;
      instr_addr_in <= ad;
      if (hit) tgt = ad + 21'h2 + {{12{n[7]}}, n, 1'b0};
      if (hit) q.push_back(33'(tgt));
      exec({bcfb_pkg::OP_BRANCH, codes[k % 4], n}, hit ? 9 : 5);
    end
    $display("test branches done");
    // status and last target after the final branch, then an unlisted code
    q.push_back({31'h0, hit, 1'b0});
    apb(bcfb_pkg::REG_STATUS, 1'b0, 32'h0);
    q.push_back(33'(tgt));
    apb(bcfb_pkg::REG_LAST_PC, 1'b0, 32'h0);
    exec({bcfb_pkg::OP_BRANCH, 4'h5, 8'h10}, 5);
    q.push_back(33'h0_0000_0004);
    apb(bcfb_pkg::REG_STATUS, 1'b0, 32'h0);
    $display("test status done");
    q.push_back(33'(n_done));
    apb(bcfb_pkg::REG_COUNT, 1'b0, 32'h0);
    // any write to the count register clears the count
    apb(bcfb_pkg::REG_COUNT, 1'b1, 32'h0);
    q.push_back(33'h0);
    apb(bcfb_pkg::REG_COUNT, 1'b0, 32'h0);
    $display("test count done");
    // disable: ready falls one cycle after the write lands
    apb(bcfb_pkg::REG_CTRL, 1'b1, 32'h0);
    repeat (2) @(negedge clk_sys_in);
    check(33'(instr_ready_out), 33'h0);
    $display("test disable done");
    repeat (3) @(posedge clk_sys_in);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
